// file: lpc_bank.v
`include "lpc_map.vh"
module lpc_bank #(
	parameter TW = `LPC_TW,
	parameter [TW-1:0] RCD_CYC = 1,
	parameter [TW-1:0] RP_CYC = 1,
	parameter [TW-1:0] RFC_CYC = 1,
	parameter [TW-1:0] BURST_CYC = 1
) (
	input wire sys_clk_i,
	input wire reset_i,
	input wire [2:0] cmd_i,
	input wire ap_i,
	output reg [2:0] state_o,
	output reg ap_o
);
	reg [TW-1:0] timer;
	wire done;
	assign done = (timer == {{(TW-1){1'b0}}, 1'b1});

	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_o <= `LPC_BS_IDLE;
			ap_o <= 1'b0;
			timer <= {TW{1'b0}};
		end else if (cmd_i == `LPC_BC_ACT) begin
			state_o <= `LPC_BS_ACTIVATING;
			timer <= RCD_CYC;
		end else if (cmd_i == `LPC_BC_RD || cmd_i == `LPC_BC_WR) begin
			// A new burst restarts the burst window in either direction.
			state_o <= (cmd_i == `LPC_BC_RD) ? `LPC_BS_READING : `LPC_BS_WRITING;
			ap_o <= ap_i;
			timer <= BURST_CYC;
		end else if (cmd_i == `LPC_BC_PRE) begin
			state_o <= `LPC_BS_PRECHARGING;
			timer <= RP_CYC;
		end else if (cmd_i == `LPC_BC_REF) begin
			state_o <= `LPC_BS_REFRESHING;
			timer <= RFC_CYC;
		end else if (done) begin
			timer <= {TW{1'b0}};
			case (state_o)
				`LPC_BS_ACTIVATING: state_o <= `LPC_BS_ACTIVE;
				`LPC_BS_READING, `LPC_BS_WRITING: begin
					if (ap_o) begin
						state_o <= `LPC_BS_PRECHARGING;
						timer <= RP_CYC;
						ap_o <= 1'b0;
					end else begin
						state_o <= `LPC_BS_ACTIVE;
					end
				end
				default: state_o <= `LPC_BS_IDLE;
			endcase
		end else if (timer != {TW{1'b0}}) begin
			timer <= timer - {{(TW-1){1'b0}}, 1'b1};
		end
	end
endmodule // lpc_bank

// file: lpc_ctrl.v
`include "lpc_map.vh"
// Summary of operation
// - Power-down exit raises clock enable with chip select high.
// - Deep power-down exit lands in power-on; a reset must follow.
// - After power-down exit only no-operations until the exit time passes.
// - Self-refresh exit returns idle; no-operations until its exit time.
// - Per-bank refresh only to an idle bank, busy for its cycle time.
// - All-bank refresh and mode-register write need every bank idle.
// - All-bank refresh and mode-register windows receive only no-operations.
// - Precharge-all only when every bank may be precharged.
// - Banks other than idle or active receive no commands except a same-direction burst with no auto-precharge pending; other banks may be used.
// - Same direction may restart a burst; direction change waits for completion.
module lpc_ctrl #(
	parameter NB = 8,
	parameter TW = `LPC_TW,
	parameter [TW-1:0] XP_CYC = `LPC_CYC2(`LPC_POWERDOWN_EXIT_NS),
	parameter [TW-1:0] XSR_CYC = `LPC_CYC2(`LPC_SELFREFRESH_EXIT_NS),
	parameter [TW-1:0] INIT_CYC = `LPC_CYC(`LPC_FINAL_INIT_WAIT_NS),
	parameter [TW-1:0] RCD_CYC = `LPC_CYC(`LPC_ROW_TO_COLUMN_NS),
	parameter [TW-1:0] RP_CYC = `LPC_CYC(`LPC_ROW_PRECHARGE_NS),
	parameter [TW-1:0] RFCPB_CYC = `LPC_CYC(`LPC_BANK_REFRESH_NS),
	parameter [TW-1:0] RFCAB_CYC = `LPC_CYC(`LPC_ALLBANK_REFRESH_NS),
	parameter [TW-1:0] MRR_CYC = `LPC_CYC(`LPC_MODEREG_READ_NS),
	parameter [TW-1:0] MRW_CYC = `LPC_CYC(`LPC_MODEREG_WRITE_NS),
	parameter [TW-1:0] BURST_CYC = `LPC_CYC(`LPC_BURST_NS)
) (
	input wire sys_clk_i,
	input wire reset_i,
	input wire req_valid_i,
	input wire [3:0] req_cmd_i,
	input wire [2:0] req_bank_i,
	input wire req_ap_i,
	input wire [9:0] req_addr_i,
	output reg req_ready_o,
	output reg req_err_o,
	output reg cke_o,
	output reg cs_n_o,
	output reg [9:0] ca_rise_o,
	output reg [9:0] ca_fall_o,
	output reg [3:0] pstate_o,
	output reg [NB-1:0] bank_busy_o
);
	// ----------------------------------------
	// Device power states
	// ----------------------------------------
	localparam [3:0] PS_POWERON = 4'h0;
	localparam [3:0] PS_RESETTING = 4'h1;
	localparam [3:0] PS_NORMAL = 4'h2;
	localparam [3:0] PS_APD = 4'h3;
	localparam [3:0] PS_IPD = 4'h4;
	localparam [3:0] PS_RPD = 4'h5;
	localparam [3:0] PS_SREF = 4'h6;
	localparam [3:0] PS_DPD = 4'h7;

	reg [3:0] pstate;
	reg [TW-1:0] gtimer;
	reg [TW-1:0] init_cnt;
	reg [3:0] next_pstate;
	reg [TW-1:0] next_gtimer;
	reg [TW-1:0] next_init_cnt;
	reg next_cke;
	reg next_cs_n;
	reg [9:0] next_ca_rise;
	reg [9:0] next_ca_fall;
	reg next_err;
	reg [NB*3-1:0] bank_cmd;
	wire [NB*3-1:0] bank_state;
	wire [NB-1:0] bank_ap;
	wire accept;
	wire init_done;
	wire low_power;

	function [2:0] bstate;
		input [NB*3-1:0] vec;
		input [2:0] idx;
		begin
			bstate = vec[idx*3 +: 3];
		end
	endfunction

	function [9:0] ca_word;
		input [3:0] code;
		input [2:0] bank;
		input ab;
		begin
			ca_word = {bank, 2'h0, ab, code};
		end
	endfunction

	// ----------------------------------------
	// Bank trackers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NB; g = g + 1) begin : gen_bank
			lpc_bank #(
				.TW(TW),
				.RCD_CYC(RCD_CYC),
				.RP_CYC(RP_CYC),
				.RFC_CYC(RFCPB_CYC),
				.BURST_CYC(BURST_CYC)
			) u_bank (
				.sys_clk_i(sys_clk_i),
				.reset_i(reset_i),
				.cmd_i(bank_cmd[g*3 +: 3]),
				.ap_i(req_ap_i),
				.state_o(bank_state[g*3 +: 3]),
				.ap_o(bank_ap[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Bank summaries
	// ----------------------------------------
	reg all_idle;
	reg all_prechargeable;
	integer i;
	integer j;
	integer k;
	always @* begin
		all_idle = 1'b1;
		all_prechargeable = 1'b1;
		for (i = 0; i < NB; i = i + 1) begin
			if (bank_state[i*3 +: 3] != `LPC_BS_IDLE)
				all_idle = 1'b0;
			if (bank_state[i*3 +: 3] != `LPC_BS_IDLE &&
				bank_state[i*3 +: 3] != `LPC_BS_ACTIVE)
				all_prechargeable = 1'b0;
		end
	end

	assign accept = req_valid_i & req_ready_o;
	assign init_done = (init_cnt == {TW{1'b0}});
	assign low_power = (pstate == PS_APD) || (pstate == PS_IPD) || (pstate == PS_RPD) ||
		(pstate == PS_SREF) || (pstate == PS_DPD);

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// Requests are only offered while the global timer is clear, so every
	// window timed by the global timer below is filled with idle cycles on the pins.
	always @* begin
		next_pstate = pstate;
		next_gtimer = (gtimer != {TW{1'b0}}) ? gtimer - {{(TW-1){1'b0}}, 1'b1} : gtimer;
		next_init_cnt = (init_cnt != {TW{1'b0}}) ? init_cnt - {{(TW-1){1'b0}}, 1'b1} : init_cnt;
		next_cke = ~low_power;
		next_cs_n = 1'b1;
		next_ca_rise = `LPC_CA_IDLE;
		next_ca_fall = `LPC_CA_IDLE;
		next_err = 1'b0;
		bank_cmd = {(NB*3){1'b0}};
		if (pstate == PS_RESETTING && init_done && gtimer == {TW{1'b0}})
			next_pstate = PS_NORMAL;
		if (accept) begin
			next_err = 1'b1;
			case (req_cmd_i)
				`LPC_UC_ACT: begin
					if (pstate == PS_NORMAL &&
						bstate(bank_state, req_bank_i) == `LPC_BS_IDLE) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word(`LPC_CA_ACT, req_bank_i, 1'b0);
						next_ca_fall = req_addr_i;
						bank_cmd[req_bank_i*3 +: 3] = `LPC_BC_ACT;
					end
				end
				`LPC_UC_RD, `LPC_UC_WR: begin
					if (pstate == PS_NORMAL &&
						(bstate(bank_state, req_bank_i) == `LPC_BS_ACTIVE ||
						(!bank_ap[req_bank_i] && bstate(bank_state, req_bank_i) ==
						((req_cmd_i == `LPC_UC_RD) ? `LPC_BS_READING : `LPC_BS_WRITING)))) begin
						// Only same-direction bursts may follow early.
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word((req_cmd_i == `LPC_UC_RD) ? `LPC_CA_RD :
							`LPC_CA_WR, req_bank_i, 1'b0);
						next_ca_fall = {req_addr_i[9:1], req_ap_i};
						bank_cmd[req_bank_i*3 +: 3] = (req_cmd_i == `LPC_UC_RD) ?
							`LPC_BC_RD : `LPC_BC_WR;
					end
				end
				`LPC_UC_PRE: begin
					if (pstate == PS_NORMAL &&
						(bstate(bank_state, req_bank_i) == `LPC_BS_ACTIVE ||
						bstate(bank_state, req_bank_i) == `LPC_BS_IDLE)) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word(`LPC_CA_PRE, req_bank_i, 1'b0);
						bank_cmd[req_bank_i*3 +: 3] = `LPC_BC_PRE;
					end
				end
				`LPC_UC_PREA: begin
					if (pstate == PS_NORMAL && all_prechargeable) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word(`LPC_CA_PRE, 3'h0, 1'b1);
						next_gtimer = RP_CYC;
						for (j = 0; j < NB; j = j + 1)
							bank_cmd[j*3 +: 3] = `LPC_BC_PRE;
					end
				end
				`LPC_UC_REFPB: begin
					if (pstate == PS_NORMAL &&
						bstate(bank_state, req_bank_i) == `LPC_BS_IDLE) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word(`LPC_CA_REFPB, req_bank_i, 1'b0);
						bank_cmd[req_bank_i*3 +: 3] = `LPC_BC_REF;
					end
				end
				`LPC_UC_REFAB, `LPC_UC_MRW: begin
					if (pstate == PS_NORMAL && all_idle) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word((req_cmd_i == `LPC_UC_MRW) ? `LPC_CA_MRW :
							`LPC_CA_REFAB, 3'h0, 1'b0);
						next_ca_fall = req_addr_i;
						next_gtimer = (req_cmd_i == `LPC_UC_MRW) ? MRW_CYC : RFCAB_CYC;
					end
				end
				`LPC_UC_MRR: begin
					if ((pstate == PS_NORMAL && all_prechargeable) ||
						pstate == PS_RESETTING) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word(`LPC_CA_MRR, 3'h0, 1'b0);
						next_ca_fall = req_addr_i;
						next_gtimer = MRR_CYC;
					end
				end
				`LPC_UC_RESET: begin
					if (pstate == PS_POWERON || (pstate == PS_NORMAL && all_idle)) begin
						next_err = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word(`LPC_CA_MRW, 3'h0, 1'b0);
						next_ca_fall = req_addr_i;
						next_pstate = PS_RESETTING;
						next_gtimer = MRW_CYC;
						next_init_cnt = INIT_CYC;
					end
				end
				`LPC_UC_PDE: begin
					if ((pstate == PS_NORMAL && all_prechargeable) ||
						pstate == PS_RESETTING) begin
						next_err = 1'b0;
						next_cke = 1'b0;
						next_pstate = (pstate == PS_RESETTING) ? PS_RPD :
							(all_idle ? PS_IPD : PS_APD);
					end
				end
				`LPC_UC_SREF, `LPC_UC_DPD: begin
					if (pstate == PS_NORMAL && all_idle) begin
						next_err = 1'b0;
						next_cke = 1'b0;
						next_cs_n = 1'b0;
						next_ca_rise = ca_word((req_cmd_i == `LPC_UC_SREF) ? `LPC_CA_SREF :
							`LPC_CA_DPD, 3'h0, 1'b0);
						// The memory floats or terminates its own data pins in self
						// refresh; this block drives none of them, so it cannot fight it.
						next_pstate = (req_cmd_i == `LPC_UC_SREF) ? PS_SREF : PS_DPD;
					end
				end
				`LPC_UC_EXIT: begin
					if (low_power) begin
						next_err = 1'b0;
						next_cke = 1'b1;
						next_gtimer = (pstate == PS_SREF) ? XSR_CYC : XP_CYC;
						case (pstate)
							PS_RPD: next_pstate = init_done ? PS_NORMAL : PS_RESETTING;
							PS_DPD: next_pstate = PS_POWERON;
							default: next_pstate = PS_NORMAL;
						endcase
					end
				end
				default: next_err = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Registers and pins
	// ----------------------------------------
	// Ready waits one cycle after any accepted request so that the bank
	// states seen by the next request already include the last command.
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			pstate <= PS_POWERON;
			gtimer <= {TW{1'b0}};
			init_cnt <= {TW{1'b0}};
			req_ready_o <= 1'b0;
			req_err_o <= 1'b0;
			cke_o <= 1'b1;
			cs_n_o <= 1'b1;
			ca_rise_o <= `LPC_CA_IDLE;
			ca_fall_o <= `LPC_CA_IDLE;
			pstate_o <= PS_POWERON;
			bank_busy_o <= {NB{1'b0}};
		end else begin
			pstate <= next_pstate;
			gtimer <= next_gtimer;
			init_cnt <= next_init_cnt;
			req_ready_o <= ~accept && (next_gtimer == {TW{1'b0}}) && next_cke == cke_o;
			req_err_o <= next_err;
			cke_o <= next_cke;
			cs_n_o <= next_cs_n;
			ca_rise_o <= next_ca_rise;
			ca_fall_o <= next_ca_fall;
			pstate_o <= next_pstate;
			for (k = 0; k < NB; k = k + 1)
				bank_busy_o[k] <= (bank_state[k*3 +: 3] != `LPC_BS_IDLE) ||
					(bank_cmd[k*3 +: 3] != `LPC_BC_NONE);
		end
	end
endmodule // lpc_ctrl

// file: lpc_ctrl_bench.sv
`include "lpc_map.vh"
module lpc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic [3:0] req_cmd_i = 4'h0;
	logic [2:0] req_bank_i = 3'h0;
	logic req_ap_i = 1'b0;
	logic [9:0] req_addr_i = 10'h2A5;
	wire req_ready_o, req_err_o, cke_o, cs_n_o, dev_viol;
	wire [9:0] ca_rise_o, ca_fall_o;
	wire [3:0] pstate_o, dev_state;
	wire [7:0] bank_busy_o;
	int n_errors = 0;
	int num_checks = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	lpc_ctrl u_lpc_ctrl (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
		.req_bank_i(req_bank_i), .req_ap_i(req_ap_i), .req_addr_i(req_addr_i),
		.req_ready_o(req_ready_o), .req_err_o(req_err_o), .cke_o(cke_o), .cs_n_o(cs_n_o),
		.ca_rise_o(ca_rise_o), .ca_fall_o(ca_fall_o), .pstate_o(pstate_o),
		.bank_busy_o(bank_busy_o));
	lpc_dev_model u_lpc_dev_model (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .cke_i(cke_o), .cs_n_i(cs_n_o), .ca_rise_i(ca_rise_o),
		.ca_fall_i(ca_fall_o), .state_o(dev_state), .viol_o(dev_viol));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	always @(negedge sys_clk_i) begin
		if (dev_viol === 1'b1) chk(1'b1, 1'b0);
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#10;
	endtask
	// Valid is raised once ready is high, or after 300 cycles of waiting; with ready high the next edge takes it.
	task automatic send(input logic [3:0] c, input logic [2:0] b, input logic ap);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		chk(n < 300, 1'b1);
		req_valid_i = 1'b1;
		req_cmd_i = c;
		req_bank_i = b;
		req_ap_i = ap;
		tick(1);
		req_valid_i = 1'b0;
	endtask
	task automatic t_init;
		chk(pstate_o, 4'h0);
		send(`LPC_UC_ACT, 3'h0, 1'b0);
		chk({req_err_o, cs_n_o}, 2'h3);
		send(`LPC_UC_RESET, 3'h0, 1'b0);
		chk({cs_n_o, ca_rise_o, pstate_o}, {1'b0, 10'h000, 4'h1});
		for (int n = 0; n < 300 && pstate_o !== 4'h2; n++) tick(1);
		chk(pstate_o, 4'h2);
		$display("Test init done");
	endtask
	task automatic t_bank;
		send(`LPC_UC_ACT, 3'h2, 1'b0);
		chk({cs_n_o, ca_rise_o, bank_busy_o[2]}, {1'b0, 10'h102, 1'b1});
		send(`LPC_UC_ACT, 3'h2, 1'b0);
		chk(req_err_o, 1'b1);
		tick(3);
		send(`LPC_UC_RD, 3'h2, 1'b0);
		chk({ca_rise_o, ca_fall_o}, {10'h105, req_addr_i[9:1], 1'b0});
		send(`LPC_UC_RD, 3'h2, 1'b1);
		chk(ca_fall_o[0], 1'b1);
		tick(12);
		chk(bank_busy_o[2], 1'b0);
		send(`LPC_UC_PRE, 3'h5, 1'b0);
		chk({ca_rise_o, bank_busy_o[5]}, {10'h28B, 1'b1});
		$display("Test bank done");
	endtask
	task automatic t_refresh;
		tick(4);
		send(`LPC_UC_REFPB, 3'h1, 1'b0);
		chk(ca_rise_o, 10'h084);
		tick(4);
		send(`LPC_UC_REFAB, 3'h0, 1'b0);
		chk(ca_rise_o[3:0], `LPC_CA_REFAB);
		send(`LPC_UC_MRR, 3'h0, 1'b0);
		chk(ca_rise_o[3:0], `LPC_CA_MRR);
		send(`LPC_UC_MRW, 3'h0, 1'b0);
		chk({ca_rise_o[3:0], pstate_o}, {`LPC_CA_MRW, 4'h2});
		send(`LPC_UC_ACT, 3'h3, 1'b0);
		tick(4);
		send(`LPC_UC_REFAB, 3'h0, 1'b0);
		chk({req_err_o, cs_n_o}, 2'h3);
		$display("Test refresh done");
	endtask
	task automatic t_power;
		send(`LPC_UC_PDE, 3'h0, 1'b0);
		chk({cke_o, pstate_o}, {1'b0, 4'h3});
		tick(5);
		chk(pstate_o, 4'h3);
		send(`LPC_UC_EXIT, 3'h0, 1'b0);
		chk({cke_o, cs_n_o, pstate_o}, {2'h3, 4'h2});
		send(`LPC_UC_PREA, 3'h0, 1'b0);
		chk({ca_rise_o[4], ca_rise_o[3:0]}, {1'b1, `LPC_CA_PRE});
		tick(4);
		send(`LPC_UC_PDE, 3'h0, 1'b0);
		chk(pstate_o, 4'h4);
		send(`LPC_UC_EXIT, 3'h0, 1'b0);
		chk(pstate_o, 4'h2);
		send(`LPC_UC_SREF, 3'h0, 1'b0);
		chk({cke_o, cs_n_o, ca_rise_o[3:0], pstate_o}, {2'h0, `LPC_CA_SREF, 4'h6});
		send(`LPC_UC_EXIT, 3'h0, 1'b0);
		chk(pstate_o, 4'h2);
		send(`LPC_UC_ACT, 3'h0, 1'b0);
		tick(4);
		send(`LPC_UC_SREF, 3'h0, 1'b0);
		chk({req_err_o, cke_o}, 2'h3);
		send(`LPC_UC_PRE, 3'h0, 1'b0);
		tick(4);
		send(`LPC_UC_DPD, 3'h0, 1'b0);
		chk({ca_rise_o[3:0], pstate_o}, {`LPC_CA_DPD, 4'h7});
		send(`LPC_UC_EXIT, 3'h0, 1'b0);
		chk(pstate_o, 4'h0);
		send(`LPC_UC_RESET, 3'h0, 1'b0);
		send(`LPC_UC_PDE, 3'h0, 1'b0);
		chk(pstate_o, 4'h5);
		send(`LPC_UC_EXIT, 3'h0, 1'b0);
		chk(pstate_o, 4'h1);
		send(`LPC_UC_PDE, 3'h0, 1'b0);
		tick(110);
		send(`LPC_UC_EXIT, 3'h0, 1'b0);
		chk(pstate_o, 4'h2);
		tick(3);
		chk(dev_state, pstate_o);
		$display("Test power done");
	endtask
	task automatic finish_test;
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// The tests need about 400 cycles; 3000 leaves room for slow timers.
	initial begin
		#300000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge sys_clk_i);
		#10;
		reset_i = 1'b0;
		tick(2);
		t_init();
		t_bank();
		t_refresh();
		t_power();
		finish_test();
	end
endmodule // lpc_ctrl_bench

// file: lpc_ctrl_props.sv
`include "lpc_map.vh"
module lpc_ctrl_props #(parameter NB = 8) (
	input wire sys_clk_i,
	input wire reset_i,
	input wire req_valid_i,
	input wire req_ready_o,
	input wire req_err_o,
	input wire cke_o,
	input wire cs_n_o,
	input wire [9:0] ca_rise_o,
	input wire [9:0] ca_fall_o,
	input wire [3:0] pstate_o,
	input wire [NB-1:0] bank_busy_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_exit;
		$rose(cke_o);
	endsequence
	sequence s_act;
		!cs_n_o && cke_o && ca_rise_o[3:0] == `LPC_CA_ACT;
	endsequence
	property p_idle_pins;
		cs_n_o |-> ca_rise_o == `LPC_CA_IDLE && ca_fall_o == `LPC_CA_IDLE;
	endproperty
	a_idle_pins: assert property (p_idle_pins) else $error("CA bus busy while deselected.");
	property p_one_cycle;
		!cs_n_o |=> cs_n_o;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("Select held too long.");
	property p_cause;
		!cs_n_o |-> $past(req_valid_i && req_ready_o);
	endproperty
	a_cause: assert property (p_cause) else $error("Command without a request.");
	property p_gap;
		req_valid_i && req_ready_o |=> !req_ready_o;
	endproperty
	a_gap: assert property (p_gap) else $error("Ready stayed high after accept.");
	property p_hold_pd;
		!cke_o && !$past(cke_o) |-> $stable(pstate_o);
	endproperty
	a_hold_pd: assert property (p_hold_pd) else $error("Low power state changed.");
	property p_exit_nop;
		s_exit |-> cs_n_o [*2];
	endproperty
	a_exit_nop: assert property (p_exit_nop) else $error("Command inside exit time.");
	property p_pd_entry;
		$fell(cke_o) && cs_n_o |-> pstate_o inside {4'h3, 4'h4, 4'h5};
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("Bad power-down state.");
	property p_sr_entry;
		$fell(cke_o) && !cs_n_o |-> bank_busy_o == '0 &&
			(ca_rise_o[3:0] == `LPC_CA_SREF && pstate_o == 4'h6 ||
			ca_rise_o[3:0] == `LPC_CA_DPD && pstate_o == 4'h7);
	endproperty
	a_sr_entry: assert property (p_sr_entry) else $error("Bad low power entry.");
	property p_dpd_exit;
		$past(pstate_o) == 4'h7 ##0 s_exit |-> pstate_o == 4'h0;
	endproperty
	a_dpd_exit: assert property (p_dpd_exit) else $error("Deep exit not power-on.");
	property p_err_quiet;
		req_err_o |-> cs_n_o && $stable(cke_o) ##1 !req_err_o;
	endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("Dropped command moved pins.");
	property p_act_busy;
		s_act |-> bank_busy_o[ca_rise_o[9:7]];
	endproperty
	a_act_busy: assert property (p_act_busy) else $error("Activated bank not busy.");
endmodule // lpc_ctrl_props

bind lpc_ctrl lpc_ctrl_props #(.NB(NB)) u_lpc_ctrl_props (.sys_clk_i(sys_clk_i),
	.reset_i(reset_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
	.req_err_o(req_err_o), .cke_o(cke_o), .cs_n_o(cs_n_o), .ca_rise_o(ca_rise_o),
	.ca_fall_o(ca_fall_o), .pstate_o(pstate_o), .bank_busy_o(bank_busy_o));

// file: lpc_dev_model.sv
`include "lpc_map.vh"
module lpc_dev_model #(
	parameter int XP_CYC = `LPC_CYC2(`LPC_POWERDOWN_EXIT_NS),
	parameter int XSR_CYC = `LPC_CYC2(`LPC_SELFREFRESH_EXIT_NS),
	parameter int MRW_CYC = `LPC_CYC(`LPC_MODEREG_WRITE_NS),
	parameter int MRR_CYC = `LPC_CYC(`LPC_MODEREG_READ_NS),
	parameter int RFCAB_CYC = `LPC_CYC(`LPC_ALLBANK_REFRESH_NS),
	parameter int INIT_CYC = `LPC_CYC(`LPC_FINAL_INIT_WAIT_NS)
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic [9:0] ca_rise_i,
	input wire logic [9:0] ca_fall_i,
	output logic [3:0] state_o,
	output logic viol_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_cke;
	logic [7:0] open;
	int hold;
	int init_cnt;
	wire [2:0] bk = ca_rise_i[9:7];
	wire [3:0] code = ca_rise_i[3:0];
	wire cmd = prev_cke && cke_i && !cs_n_i && ca_rise_i[2:0] != 3'h7;
	// Clock enable low on two edges falls through every branch, so the state holds.
	always @(posedge sys_clk_i) begin
		viol_o <= 1'b0;
		if (reset_i) begin
			prev_cke <= 1'b1;
			state_o <= 4'h0;
			open <= 8'h00;
			hold <= 0;
			init_cnt <= 0;
		end else begin
			prev_cke <= cke_i;
			if (hold > 0) hold <= hold - 1;
			if (init_cnt > 0) init_cnt <= init_cnt - 1;
			if (state_o == 4'h1 && init_cnt == 0 && hold == 0) state_o <= 4'h2;
			if (!prev_cke && cke_i) begin
				viol_o <= cs_n_i !== 1'b1;
				hold <= (state_o == 4'h6 ? XSR_CYC : XP_CYC) - 1;
				case (state_o)
					4'h7: state_o <= 4'h0;
					4'h5: state_o <= init_cnt == 0 ? 4'h2 : 4'h1;
					default: state_o <= 4'h2;
				endcase
			end else if (prev_cke && !cke_i) begin
				if (cs_n_i) state_o <= state_o == 4'h1 ? 4'h5 : (|open ? 4'h3 : 4'h4);
				else state_o <= code == `LPC_CA_DPD ? 4'h7 : 4'h6;
				viol_o <= !cs_n_i && |open;
			end else if (cmd) begin
				viol_o <= hold > 0 || state_o == 4'h0 && code != `LPC_CA_MRW;
				case (code)
					`LPC_CA_ACT: begin
						viol_o <= hold > 0 || open[bk];
						open[bk] <= 1'b1;
					end
					`LPC_CA_RD, `LPC_CA_WR: begin
						viol_o <= hold > 0 || !open[bk];
						if (ca_fall_i[0]) open[bk] <= 1'b0;
					end
					`LPC_CA_PRE: begin
						if (ca_rise_i[4]) open <= 8'h00;
						else open[bk] <= 1'b0;
					end
					`LPC_CA_REFPB: viol_o <= hold > 0 || open[bk];
					`LPC_CA_REFAB: begin
						viol_o <= hold > 0 || |open;
						hold <= RFCAB_CYC - 1;
					end
					`LPC_CA_MRR: hold <= MRR_CYC - 1;
					`LPC_CA_MRW: begin
						viol_o <= hold > 0 || |open;
						hold <= MRW_CYC - 1;
						if (state_o == 4'h0) begin
							state_o <= 4'h1;
							init_cnt <= INIT_CYC;
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule // lpc_dev_model

// file: lpc_map.vh
`ifndef LPC_MAP_VH
`define LPC_MAP_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define LPC_CLK_NS 100
`define LPC_CYC(ns) ((((ns) + `LPC_CLK_NS - 1) / `LPC_CLK_NS) < 1 ? 1 : \
	(((ns) + `LPC_CLK_NS - 1) / `LPC_CLK_NS))
`define LPC_CYC2(ns) (`LPC_CYC(ns) < 2 ? 2 : `LPC_CYC(ns))
`define LPC_POWERDOWN_EXIT_NS 10
`define LPC_SELFREFRESH_EXIT_NS 220
`define LPC_FINAL_INIT_WAIT_NS 10000
`define LPC_ROW_TO_COLUMN_NS 20
`define LPC_ROW_PRECHARGE_NS 20
`define LPC_BANK_REFRESH_NS 90
`define LPC_ALLBANK_REFRESH_NS 130
`define LPC_MODEREG_READ_NS 400
`define LPC_MODEREG_WRITE_NS 1000
`define LPC_BURST_NS 400
`define LPC_TW 16
// ----------------------------------------
// User command codes
// ----------------------------------------
`define LPC_UC_NOP 4'h0
`define LPC_UC_ACT 4'h1
`define LPC_UC_RD 4'h2
`define LPC_UC_WR 4'h3
`define LPC_UC_PRE 4'h4
`define LPC_UC_PREA 4'h5
`define LPC_UC_REFPB 4'h6
`define LPC_UC_REFAB 4'h7
`define LPC_UC_MRR 4'h8
`define LPC_UC_MRW 4'h9
`define LPC_UC_RESET 4'hA
`define LPC_UC_PDE 4'hB
`define LPC_UC_SREF 4'hC
`define LPC_UC_DPD 4'hD
`define LPC_UC_EXIT 4'hE
// ----------------------------------------
// Command/address codes, CA3..CA0 on the rising edge
// ----------------------------------------
`define LPC_CA_MRW 4'h0
`define LPC_CA_MRR 4'h8
`define LPC_CA_REFPB 4'h4
`define LPC_CA_REFAB 4'hC
`define LPC_CA_SREF 4'h4
`define LPC_CA_ACT 4'h2
`define LPC_CA_WR 4'h1
`define LPC_CA_RD 4'h5
`define LPC_CA_PRE 4'hB
`define LPC_CA_DPD 4'h3
`define LPC_CA_IDLE 10'h3FF
`define LPC_CA_AB_BIT 4
`define LPC_CA_BANK_LSB 7
// ----------------------------------------
// Bank states and bank commands
// ----------------------------------------
`define LPC_BS_IDLE 3'h0
`define LPC_BS_ACTIVATING 3'h1
`define LPC_BS_ACTIVE 3'h2
`define LPC_BS_READING 3'h3
`define LPC_BS_WRITING 3'h4
`define LPC_BS_PRECHARGING 3'h5
`define LPC_BS_REFRESHING 3'h6
`define LPC_BC_NONE 3'h0
`define LPC_BC_ACT 3'h1
`define LPC_BC_RD 3'h2
`define LPC_BC_WR 3'h3
`define LPC_BC_PRE 3'h4
`define LPC_BC_REF 3'h5
`endif
